// ===== sec_engine_control.sv
// sequencing engine control, condition selection and ahb-lite registers
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.svh"

module sec_engine_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire sec_pkg::sec_state_cfg_t state_cfg,
    input wire sec_pkg::sec_inputs_t monitor_inputs,
    input wire logic icb_ping_received,
    output sec_pkg::sec_icb_msg_t icb_msg,
    output logic [5:0] current_state,
    output logic state_changed,
    output logic nv_access_allowed
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // input level picked by codes 1 to 11, low for all others
    function automatic logic select_input(
        input logic [3:0] code,
        input sec_pkg::sec_inputs_t inp
    );
        logic [10:0] vec;
        logic [3:0] pos;
        vec = inp;
        pos = code - `SEC_COND_FIRST_INPUT;
        select_input = 1'b0;
        if (code >= `SEC_COND_FIRST_INPUT && code <= `SEC_COND_WARNING) begin
            select_input = vec[pos];
        end
    endfunction

    function automatic logic is_reg(
        input logic [7:0] idx,
        input logic [7:0] reg_idx
    );
        is_reg = (idx == reg_idx);
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [7:0] dp_index;
    logic ap_take;
    logic [7:0] ap_index;
    logic wr_ctrl;
    logic wr_key;
    logic wr_restart;
    logic [7:0] wdata_byte;
    logic halt;
    logic step_req;
    logic jump_req;
    logic restart_pending;
    sec_pkg::sec_unlock_t unlock_state;
    sec_pkg::sec_unlock_t next_unlock_state;
    logic [3:0] code;
    logic level_met;
    logic ping_go;
    logic pong_go;
    logic cond_advance;
    logic advance;
    logic restart_go;
    logic state_move;
    logic [31:0] next_hrdata;

    // ------------------------------------------------------------
    // ahb-lite address and data phase
    // ------------------------------------------------------------

    // only whole-word transfers are expected; narrower ones act on the low byte
    assign ap_take = hsel && hready && htrans[1];
    assign ap_index = haddr[9:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
        end else if (hready) begin
            dp_valid <= ap_take;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
        end else if (hready) begin
            dp_write <= hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_index <= 8'h00;
        end else if (hready) begin
            dp_index <= ap_index;
        end
    end

    // ------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------

    assign wdata_byte = hwdata[7:0];
    assign wr_ctrl = dp_valid && dp_write && is_reg(dp_index, `SEC_IDX_ENGINE_CONTROL);
    assign wr_key = dp_valid && dp_write && is_reg(dp_index, `SEC_IDX_RESTART_UNLOCK_KEY);
    assign wr_restart = dp_valid && dp_write && is_reg(dp_index, `SEC_IDX_ENGINE_RESTART);

    // ------------------------------------------------------------
    // ahb-lite response
    // ------------------------------------------------------------

    // zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    // read data is registered during the address phase so it stands
    // through the data phase; write-only and unmapped words read zero
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (is_reg(ap_index, `SEC_IDX_ENGINE_CONTROL)) begin
            next_hrdata[`SEC_CTRL_HALT_BIT] = halt;
            next_hrdata[`SEC_CTRL_STEP_BIT] = step_req;
        end else if (is_reg(ap_index, `SEC_IDX_CURRENT_STATE)) begin
            next_hrdata[5:0] = current_state; // [RULE11]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= next_hrdata;
        end
    end

    // ------------------------------------------------------------
    // engine control bits
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt <= `SEC_HALT_RESET;
        end else if (wr_ctrl) begin
            halt <= wdata_byte[`SEC_CTRL_HALT_BIT];
        end
    end

    // ------------------------------------------------------------
    // nonvolatile access gate
    // ------------------------------------------------------------

    // nonvolatile state memory may only be touched while halted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nv_access_allowed <= 1'b0;
        end else begin
            nv_access_allowed <= halt; // [RULE10]
        end
    end

    // ------------------------------------------------------------
    // step and jump requests
    // ------------------------------------------------------------

    // a new write wins over the clear of the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_req <= 1'b0;
        end else if (wr_ctrl && wdata_byte[`SEC_CTRL_STEP_BIT]) begin
            step_req <= 1'b1;
        end else if (state_move) begin
            step_req <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jump_req <= 1'b0;
        end else if (wr_ctrl && wdata_byte[`SEC_CTRL_JUMP_BIT]) begin
            jump_req <= 1'b1;
        end else if (state_move) begin
            jump_req <= 1'b0; // [RULE7]
        end
    end

    // ------------------------------------------------------------
    // restart unlock tracker
    // ------------------------------------------------------------

    // only writes to the key register count; other registers in between
    // do not break the pair
    always_comb begin
        next_unlock_state = unlock_state;
        if (wr_key) begin
            unique case (unlock_state)
                sec_pkg::SEC_LOCKED: begin
                    if (wdata_byte == `SEC_KEY_FIRST) begin
                        next_unlock_state = sec_pkg::SEC_KEY1_SEEN;
                    end
                end
                sec_pkg::SEC_KEY1_SEEN: begin
                    if (wdata_byte == `SEC_KEY_SECOND) begin
                        next_unlock_state = sec_pkg::SEC_UNLOCKED; // [RULE12]
                    end else if (wdata_byte == `SEC_KEY_FIRST) begin
                        next_unlock_state = sec_pkg::SEC_KEY1_SEEN;
                    end else begin
                        next_unlock_state = sec_pkg::SEC_LOCKED;
                    end
                end
                sec_pkg::SEC_UNLOCKED: begin
                    if (wdata_byte == `SEC_KEY_LOCK) begin
                        next_unlock_state = sec_pkg::SEC_LOCKED; // [RULE13]
                    end
                end
                default: begin
                    next_unlock_state = sec_pkg::SEC_LOCKED;
                end
            endcase
        end
    end

    // restart writes never touch the tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock_state <= sec_pkg::SEC_LOCKED; // [RULE20]
        end else begin
            unlock_state <= next_unlock_state; // [RULE14]
        end
    end

    // ------------------------------------------------------------
    // restart request
    // ------------------------------------------------------------
    assign restart_go = restart_pending && !halt; // [RULE15] [RULE16]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart_pending <= 1'b0;
        end else if (wr_restart && wdata_byte[`SEC_RESTART_BIT]
                     && unlock_state == sec_pkg::SEC_UNLOCKED) begin
            restart_pending <= 1'b1;
        end else if (restart_go) begin
            restart_pending <= 1'b0; // [RULE17]
        end
    end

    // ------------------------------------------------------------
    // advance condition
    // ------------------------------------------------------------
    assign code = state_cfg.advance_condition_code;

    // ------------------------------------------------------------
    // input selection
    // ------------------------------------------------------------

    // level inputs trigger on the level named by the polarity bit
    assign level_met = (select_input(code, monitor_inputs)
                        == state_cfg.advance_input_polarity); // [RULE2] [RULE18]

    assign ping_go = (code == `SEC_COND_SEND_PING); // [RULE4]
    assign pong_go = (code == `SEC_COND_WAIT_PING) && icb_ping_received; // [RULE5]

    always_comb begin
        cond_advance = 1'b0;
        unique case (code)
            `SEC_COND_NEVER: begin
                cond_advance = 1'b0; // [RULE1]
            end
            `SEC_COND_JUMP: begin
                cond_advance = 1'b0; // [RULE3]
            end
            `SEC_COND_RESERVED: begin
                cond_advance = 1'b0;
            end
            `SEC_COND_SEND_PING: begin
                cond_advance = 1'b1;
            end
            `SEC_COND_WAIT_PING: begin
                cond_advance = icb_ping_received;
            end
            default: begin
                cond_advance = level_met;
            end
        endcase
    end

    // ------------------------------------------------------------
    // advance decision
    // ------------------------------------------------------------

    // a step request moves even while halted, which is what makes
    // halt plus step usable for walking through a sequence
    assign advance = step_req // [RULE8]
                     || (!halt && (jump_req || cond_advance)); // [RULE6] [RULE9]
    assign state_move = restart_go || advance;

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            current_state <= `SEC_RESERVED_STATE;
        end else if (restart_go) begin
            current_state <= `SEC_RESERVED_STATE;
        end else if (advance) begin
            current_state <= state_cfg.next_state;
        end
    end

    // ------------------------------------------------------------
    // state change pulse
    // ------------------------------------------------------------

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_changed <= 1'b0;
        end else begin
            state_changed <= state_move;
        end
    end

    // ------------------------------------------------------------
    // interchip bus messages
    // ------------------------------------------------------------

    // messages only go out when the state really advances on its own
    // condition, so a halted engine stays silent on the link
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            icb_msg <= '0;
        end else begin
            icb_msg.ping <= ping_go && !halt && !restart_go;
            icb_msg.pong <= pong_go && !halt && !restart_go;
            icb_msg.addr <= state_cfg.step_delay_code; // [RULE19]
        end
    end

endmodule // sec_engine_control
`default_nettype wire

// ===== sec_defs.svh
// constants for the sequencing engine control block
// What this block does
// [RULE1] code zero never advances the state
// [RULE2] codes 1-11 select supply, high-voltage, aux, warning inputs
// [RULE3] code 12 waits for software jump
// [RULE4] code 14 sends ping to delay-field address
// [RULE5] code 15 waits ping, replies pong
// [RULE6] jump bit forces move to next state
// [RULE7] jump bit self clears after state change
// [RULE8] single step advances one state
// [RULE9] halt blocks all state transitions except single step
// [RULE10] nonvolatile access allowed only while halted
// [RULE11] current state register reports six-bit state
// [RULE12] key 0x27 then 0x10 unlocks restart
// [RULE13] key 0x00 relocks the restart register
// [RULE14] restart write keeps the unlock condition
// [RULE15] restart while running goes to reserved state
// [RULE16] restart while halted waits for halt clear
// [RULE17] restart bit self clears once accepted
// [RULE18] polarity bit picks high or low trigger
// [RULE19] delay field gives interchip bus address
// [RULE20] reset leaves tracker locked, expecting first key
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SEC_IDX_ENGINE_CONTROL 8'h93
`define SEC_IDX_RESTART_UNLOCK_KEY 8'hDA
`define SEC_IDX_ENGINE_RESTART 8'hDB
`define SEC_IDX_CURRENT_STATE 8'hE9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEC_CTRL_HALT_BIT 0
`define SEC_CTRL_STEP_BIT 1
`define SEC_CTRL_JUMP_BIT 2
`define SEC_RESTART_BIT 0

// ----------------------------------------------------------------
// key values and reset values
// ----------------------------------------------------------------
`define SEC_KEY_FIRST 8'h27
`define SEC_KEY_SECOND 8'h10
`define SEC_KEY_LOCK 8'h00
`define SEC_RESERVED_STATE 6'h00
`define SEC_HALT_RESET 1'b0

// ----------------------------------------------------------------
// advance condition codes
// ----------------------------------------------------------------
`define SEC_COND_NEVER 4'h0
`define SEC_COND_FIRST_INPUT 4'h1
`define SEC_COND_WARNING 4'hB
`define SEC_COND_JUMP 4'hC
`define SEC_COND_RESERVED 4'hD
`define SEC_COND_SEND_PING 4'hE
`define SEC_COND_WAIT_PING 4'hF

`endif

// ===== sec_pkg.sv
// types shared by the sequencing engine control block
package sec_pkg;

    // ------------------------------------------------------------
    // unlock tracker states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SEC_LOCKED = 3'b001,
        SEC_KEY1_SEEN = 3'b010,
        SEC_UNLOCKED = 3'b100
    } sec_unlock_t;

    // ------------------------------------------------------------
    // per-state configuration of the present state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] advance_condition_code;
        logic advance_input_polarity;
        logic [3:0] step_delay_code;
        logic [5:0] next_state;
    } sec_state_cfg_t;

    // ------------------------------------------------------------
    // supervised inputs, as comparator levels
    // ------------------------------------------------------------
    typedef struct packed {
        logic warning;
        logic aux_input_five;
        logic aux_input_four;
        logic aux_input_three;
        logic aux_input_two;
        logic aux_input_one;
        logic high_voltage_input;
        logic supply_input_four;
        logic supply_input_three;
        logic supply_input_two;
        logic supply_input_one;
    } sec_inputs_t;

    // ------------------------------------------------------------
    // interchip bus message toward the link logic
    // ------------------------------------------------------------
    typedef struct packed {
        logic ping;
        logic pong;
        logic [3:0] addr;
    } sec_icb_msg_t;

endpackage

// ===== sec_engine_control_checker.sv
// concurrent checks on the sequencing engine control ports
`timescale 1ns/1ps
`default_nettype none
module sec_engine_control_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire sec_pkg::sec_state_cfg_t state_cfg,
    input wire sec_pkg::sec_inputs_t monitor_inputs,
    input wire logic icb_ping_received,
    input wire sec_pkg::sec_icb_msg_t icb_msg,
    input wire logic [5:0] current_state,
    input wire logic state_changed,
    input wire logic nv_access_allowed
);
    logic [2:0] since_wr;
    logic quiet;
    logic in_code;
    logic hit;
    logic [3:0] code;
    // writes may set step, jump, halt or restart, so engine checks wait until the bus has been quiet
    assign code = state_cfg.advance_condition_code;
    assign quiet = since_wr == 3'h7;
    assign in_code = code inside {[4'h1:4'hB]};
    assign hit = in_code && monitor_inputs[code - 4'h1] == state_cfg.advance_input_polarity;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) since_wr <= 3'h0;
        else if (hsel && hready && htrans[1] && hwrite) since_wr <= 3'h0;
        else if (!quiet) since_wr <= since_wr + 3'h1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_never_codes: assert property (quiet && code inside {4'h0, 4'hC, 4'hD} |=> $stable(current_state))
        else $error("state moved on a never condition");
    a_input_advance: assert property (quiet && !nv_access_allowed && hit |=> current_state == $past(state_cfg.next_state))
        else $error("selected input did not advance");
    a_input_hold: assert property (quiet && in_code && !hit |=> $stable(current_state))
        else $error("state moved without its input");
    a_halt_blocks: assert property (quiet && nv_access_allowed |=> $stable(current_state))
        else $error("state moved while halted");
    a_ping_send: assert property (quiet && !nv_access_allowed && code == 4'hE |=> (icb_msg.ping && icb_msg.addr == $past(state_cfg.step_delay_code)))
        else $error("ping missing or wrong address");
    a_pong_send: assert property (quiet && !nv_access_allowed && code == 4'hF && icb_ping_received |=> (icb_msg.pong && icb_msg.addr == $past(state_cfg.step_delay_code)))
        else $error("pong missing or wrong address");
    a_pong_wait: assert property (quiet && code == 4'hF && !icb_ping_received |=> $stable(current_state))
        else $error("moved before a ping came in");
    a_ping_cause: assert property (icb_msg.ping |-> $past(code) == 4'hE)
        else $error("ping without send condition");
    a_change_pulse: assert property ($changed(current_state) |-> state_changed)
        else $error("state change without its pulse");
endmodule // sec_engine_control_checker
`default_nettype wire

// ===== tb_top.sv
// self-checking testbench for the sequencing engine control block
`timescale 1ns/1ps
`default_nettype none
`include "sec_defs.svh"
module tb_top;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, icb_ping_received;
    logic nv_access_allowed, state_changed;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] current_state, last_msg;
    sec_pkg::sec_state_cfg_t state_cfg;
    sec_pkg::sec_inputs_t monitor_inputs;
    sec_pkg::sec_icb_msg_t icb_msg;
    int num_errors, n_checks, cyc, k;
    logic [5:0] prev;
    assign hready = hreadyout;
    sec_engine_control sec_engine_control_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .state_cfg, .monitor_inputs, .icb_ping_received,
        .icb_msg, .current_state, .state_changed, .nv_access_allowed);
    initial begin
        hclk = 1'h0;
        forever #12.5 hclk = ~hclk;
    end
    // keep the last ping or pong so short pulses are not missed
    always @(posedge hclk) if (icb_msg.ping || icb_msg.pong) last_msg <= icb_msg;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] v);
        hsel <= 1'h1; haddr <= {22'h0, idx, 2'h0}; htrans <= 2'h2; hwrite <= 1'h1;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= {24'h0, v};
        do @(posedge hclk); while (hready !== 1'h1);
    endtask
    task rd(input logic [7:0] idx, output logic [31:0] v);
        hsel <= 1'h1; haddr <= {22'h0, idx, 2'h0}; htrans <= 2'h2; hwrite <= 1'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0; htrans <= 2'h0;
        do @(posedge hclk); while (hready !== 1'h1);
        v = hrdata;
    endtask
    task cfg(input logic [3:0] c, input logic p, input logic [3:0] dl, input logic [5:0] n);
        state_cfg <= {c, p, dl, n};
    endtask
    task goto(input logic [5:0] n);
        cfg(4'hE, 1'h0, 4'h0, n);
        tick(1);
        cfg(4'h0, 1'h0, 4'h0, n);
        tick(2);
    endtask
    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'h0; hsel = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2;
        hwdata = 32'h0; state_cfg = '0; monitor_inputs = '0; icb_ping_received = 1'h0;
        num_errors = 0; n_checks = 0; cyc = 0;
        tick(8);
        hresetn <= 1'h1;
        tick(1);
        rd(`SEC_IDX_CURRENT_STATE, d); chk(d, 32'h0);
        chk(hresp, 32'h0);
        rd(8'h10, d); chk(d, 32'h0);
        cfg(4'h0, 1'h0, 4'h0, 6'h32);
        monitor_inputs <= '1;
        tick(5); chk(current_state, 32'h0);
        prev = 6'h0;
        for (k = 1; k <= 11; k++) begin
            monitor_inputs <= ~(11'h1 << (k - 1));
            cfg(k[3:0], 1'h1, 4'h0, 6'(10 + k));
            tick(4); chk(current_state, prev);
            monitor_inputs <= 11'h1 << (k - 1);
            tick(3); chk(current_state, 10 + k);
            prev = 6'(10 + k);
        end
        // low polarity: high input holds, low input advances
        cfg(4'hB, 1'h0, 4'h0, 6'h1E);
        tick(4); chk(current_state, prev);
        monitor_inputs <= '0;
        tick(3); chk(current_state, 32'h1E);
        cfg(4'hE, 1'h0, 4'hA, 6'h05);
        tick(1);
        cfg(4'h0, 1'h0, 4'h0, 6'h05);
        tick(3); chk(current_state, 32'h05);
        chk(last_msg, 32'h2A);
        cfg(4'hF, 1'h0, 4'h6, 6'h14);
        tick(4); chk(current_state, 32'h05);
        icb_ping_received <= 1'h1;
        tick(1);
        icb_ping_received <= 1'h0;
        tick(3); chk(current_state, 32'h14);
        chk(last_msg, 32'h16);
        cfg(4'hD, 1'h0, 4'h0, 6'h21);
        tick(4); chk(current_state, 32'h14);
        cfg(4'hC, 1'h0, 4'h0, 6'h21);
        tick(4); chk(current_state, 32'h14);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h04);
        tick(3); chk(current_state, 32'h21);
        // a jump left standing would carry the engine on to the new next state
        cfg(4'hC, 1'h0, 4'h0, 6'h22);
        tick(3); chk(current_state, 32'h21);
        rd(`SEC_IDX_ENGINE_CONTROL, d); chk(d, 32'h0);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h01);
        cfg(4'hE, 1'h0, 4'h0, 6'h28);
        tick(4); chk(current_state, 32'h21);
        chk(nv_access_allowed, 32'h1);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h03);
        tick(3); chk(current_state, 32'h28);
        cfg(4'h0, 1'h0, 4'h0, 6'h28);
        rd(`SEC_IDX_ENGINE_CONTROL, d); chk(d, 32'h1);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h00);
        tick(2); chk(nv_access_allowed, 32'h0);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h28);
        // a foreign byte between the keys must not unlock
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, `SEC_KEY_FIRST);
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, 8'h55);
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, `SEC_KEY_SECOND);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h28);
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, `SEC_KEY_FIRST);
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, `SEC_KEY_SECOND);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h0);
        goto(6'h09);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h0);
        goto(6'h09);
        tick(3); chk(current_state, 32'h09);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h01);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h09);
        wr(`SEC_IDX_ENGINE_CONTROL, 8'h00);
        tick(3); chk(current_state, 32'h0);
        wr(`SEC_IDX_RESTART_UNLOCK_KEY, `SEC_KEY_LOCK);
        goto(6'h09);
        wr(`SEC_IDX_ENGINE_RESTART, 8'h01);
        tick(3); chk(current_state, 32'h09);
        complete_run();
    end
endmodule // tb_top
bind sec_engine_control sec_engine_control_checker sec_engine_control_checker_inst (.hclk, .hresetn, .hsel,
    .htrans, .hwrite, .hready, .state_cfg, .monitor_inputs, .icb_ping_received, .icb_msg, .current_state,
    .state_changed, .nv_access_allowed);
`default_nettype wire
